//--- core/rcb_consts.vh
`ifndef RCB_CONSTS_VH
`define RCB_CONSTS_VH
// Register offsets within the 256-location control block
`define RCB_OFS_PA_PIN_IN    8'h00
`define RCB_OFS_PB_PIN_IN    8'h01
`define RCB_OFS_PA_FUNC      8'h02
`define RCB_OFS_PB_FUNC      8'h03
`define RCB_OFS_PA_OUT       8'h04
`define RCB_OFS_PB_OUT       8'h05
`define RCB_OFS_PA_DIR       8'h06
`define RCB_OFS_PB_DIR       8'h07
`define RCB_OFS_PA_DRV       8'h08
`define RCB_OFS_PB_DRV       8'h09
`define RCB_OFS_PA_ICELL     8'h0a
`define RCB_OFS_PB_ICELL     8'h0b
`define RCB_OFS_PA_DEN       8'h0c
`define RCB_OFS_PB_DEN       8'h0d
`define RCB_OFS_PC_PIN_IN    8'h10
`define RCB_OFS_PD_PIN_IN    8'h11
`define RCB_OFS_PC_OUT       8'h12
`define RCB_OFS_PD_OUT       8'h13
`define RCB_OFS_PC_DIR       8'h14
`define RCB_OFS_PD_DIR       8'h15
`define RCB_OFS_PC_DRV       8'h16
`define RCB_OFS_PD_DRV       8'h17
`define RCB_OFS_PC_ICELL     8'h18
`define RCB_OFS_PC_DEN       8'h1a
`define RCB_OFS_PD_DEN       8'h1b
`define RCB_OFS_CELL_AB      8'h20
`define RCB_OFS_CELL_BC      8'h21
`define RCB_OFS_MASK_AB      8'h22
`define RCB_OFS_MASK_BC      8'h23
`define RCB_OFS_PWR0         8'hb0
`define RCB_OFS_PWR2         8'hb4
`define RCB_OFS_MAIN_PROT    8'hc0
`define RCB_OFS_SEC_PROT     8'hc2
`define RCB_OFS_PWR3         8'hc7
`define RCB_OFS_PAGE         8'he0
`define RCB_OFS_MAP          8'he2
// Memory-space map fields
`define RCB_MAP_PIO_BIT      7
`define RCB_MAP_MAIN_DATA    4
`define RCB_MAP_SEC_DATA     3
`define RCB_MAP_MAIN_PROG    2
`define RCB_MAP_SEC_PROG     1
`define RCB_MAP_NV_MASK      8'h1e
// Power control 3 bit that only reset clears
`define RCB_PWR3_STICKY      8'h02
// Reset values
`define RCB_RST_BYTE         8'h00
`define RCB_RST_DRIVE        8'h00
`endif

//--- core/rcb_port.v
`include "rcb_consts.vh"
// One 8-pin I/O port: pin sync, output, direction, drive and pin mux
module rcb_port #(
  parameter HAS_FUNC = 1
) (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Pins
  input  wire [7:0] pin_raw,
  output reg  [7:0] pin_out_q,
  output reg  [7:0] pin_oe_q,
  // Register writes
  input  wire [7:0] wdata,
  input  wire       wr_func,
  input  wire       wr_out,
  input  wire       wr_dir,
  input  wire       wr_drv,
  // Macrocell and address sources
  input  wire [7:0] cell_sel,
  input  wire [7:0] cell_val,
  input  wire [7:0] addr_val,
  // Register state
  output reg  [7:0] pin_in_q,
  output reg  [7:0] func_q,
  output reg  [7:0] out_q,
  output reg  [7:0] dir_q,
  output reg  [7:0] drv_q
);
  reg  [7:0] pin_meta_q;  // First sync stage, read only by pin_in_q
  wire [7:0] level;       // Level the pin would carry
  wire [7:0] enable;      // Driver wants to drive

  // Two-stage pin synchroniser
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta_q <= `RCB_RST_BYTE;
      pin_in_q   <= `RCB_RST_BYTE;
    end
    else
    begin
      pin_meta_q <= pin_raw;
      pin_in_q   <= pin_meta_q;
    end
  end

  // Software-visible port registers
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      func_q <= `RCB_RST_BYTE;
      out_q  <= `RCB_RST_BYTE;
      dir_q  <= `RCB_RST_BYTE;
      drv_q  <= `RCB_RST_DRIVE;
    end
    else
    begin
      if (wr_func && HAS_FUNC != 0)
        func_q <= wdata;
      if (wr_out)
        out_q <= wdata;
      if (wr_dir)
        dir_q <= wdata;
      if (wr_drv)
        drv_q <= wdata;
    end
  end

  // Macrocell beats address mode, which beats the output register
  assign level  = (cell_sel & cell_val) | (~cell_sel & func_q & addr_val) |
                  (~cell_sel & ~func_q & out_q);
  // Open drain only pulls low, so a high level releases the pin
  assign enable = (cell_sel | func_q | dir_q) & ~(drv_q & level);

  // Registered pin drive
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_out_q <= `RCB_RST_BYTE;
      pin_oe_q  <= `RCB_RST_BYTE;
    end
    else
    begin
      pin_out_q <= level;
      pin_oe_q  <= enable;
    end
  end
endmodule

//--- core/rcb_top.v
`include "rcb_consts.vh"
//////////////////////////////////////////////////////////////////////////////
module rcb_top (
  // Clock and reset
  input  wire        CLK,
  input  wire        RESETN,
  // Core bus, strobes active high, sampled each cycle
  input  wire [15:0] ADDR,
  input  wire [7:0]  WDATA,
  input  wire        BUS_RD,
  input  wire        BUS_WR,
  input  wire        BUS_PSEN,
  input  wire        FLASH_PROG,
  // Memory decode
  input  wire [7:0]  CSIOP_BASE,
  input  wire        SRAM_SEL,
  input  wire        EXT_SEL,
  input  wire        MAIN_SEL,
  input  wire        SEC_SEL,
  // Memory read data
  input  wire [15:0] MAIN_DATA,
  input  wire [15:0] SEC_DATA,
  input  wire [7:0]  SRAM_DATA,
  input  wire [7:0]  EXT_DATA,
  // Bus answer
  output reg  [15:0] DATA_OUT,
  output reg         DATA_OE_LO,
  output reg         DATA_OE_HI,
  // Pins, one byte per port, A in bits 7:0 up to D in bits 31:24
  input  wire [31:0] PORT_PIN_IN,
  output wire [31:0] PORT_PIN_OUT,
  output wire [31:0] PORT_PIN_OE,
  output wire [31:0] PORT_DRIVE,
  // Logic array connections
  input  wire [31:0] PORT_CELL_SEL,
  input  wire [31:0] PORT_CELL_VAL,
  input  wire [7:0]  IN_CELLS_A,
  input  wire [7:0]  IN_CELLS_B,
  input  wire [7:0]  IN_CELLS_C,
  output reg  [7:0]  OUT_CELL_AB,
  output reg  [7:0]  OUT_CELL_BC,
  // Non-volatile configuration
  input  wire [7:0]  NV_MAIN_PROT,
  input  wire [7:0]  NV_SEC_PROT,
  input  wire [7:0]  NV_MAP_INIT,
  // Control outputs
  output reg  [7:0]  POWER_CTRL_0,
  output reg  [7:0]  POWER_CTRL_2,
  output reg  [7:0]  POWER_CTRL_3,
  output reg  [7:0]  PAGE_SELECT,
  output reg  [7:0]  SPACE_MAP
);
  //////////////////////////////////////////////////////////////////////////
  // Decode
  wire [7:0]  ofs;          // Offset within the block
  wire        hit;          // Address falls in the block
  wire        reg_wr;       // Register write this cycle
  reg  [7:0]  addr_latch_q; // Latched address low byte
  reg  [7:0]  addr_high_q;  // Latched address high byte
  reg         map_init_q;   // Non-volatile map default loaded
  reg  [7:0]  reg_rdata;    // Selected register value
  reg  [7:0]  mask_ab_q;    // Output cell mask, bank AB
  reg  [7:0]  mask_bc_q;    // Output cell mask, bank BC
  reg  [15:0] dout_d;
  reg         oe_lo_d;
  reg         oe_hi_d;
  wire [31:0] pin_in_all;
  wire [31:0] func_all;
  wire [31:0] out_all;
  wire [31:0] dir_all;
  wire [31:0] drv_all;
  wire [31:0] wr_func_v;
  wire [31:0] wr_out_v;
  wire [31:0] wr_dir_v;
  wire [31:0] wr_drv_v;
  wire [31:0] addr_all;

  // The block is the upper address byte match; offset is the low byte
  assign ofs    = ADDR[7:0];
  assign hit    = (ADDR[15:8] == CSIOP_BASE);
  // Control block is data space only, so fetch never reaches it
  assign reg_wr = BUS_WR && hit && !BUS_PSEN;

  // Per-port write strobes; C and D have no function register
  assign wr_func_v = {16'h0000,
                      {8{reg_wr && ofs == `RCB_OFS_PB_FUNC}},
                      {8{reg_wr && ofs == `RCB_OFS_PA_FUNC}}};
  assign wr_out_v  = {{8{reg_wr && ofs == `RCB_OFS_PD_OUT}},
                      {8{reg_wr && ofs == `RCB_OFS_PC_OUT}},
                      {8{reg_wr && ofs == `RCB_OFS_PB_OUT}},
                      {8{reg_wr && ofs == `RCB_OFS_PA_OUT}}};
  assign wr_dir_v  = {{8{reg_wr && ofs == `RCB_OFS_PD_DIR}},
                      {8{reg_wr && ofs == `RCB_OFS_PC_DIR}},
                      {8{reg_wr && ofs == `RCB_OFS_PB_DIR}},
                      {8{reg_wr && ofs == `RCB_OFS_PA_DIR}}};
  assign wr_drv_v  = {{8{reg_wr && ofs == `RCB_OFS_PD_DRV}},
                      {8{reg_wr && ofs == `RCB_OFS_PC_DRV}},
                      {8{reg_wr && ofs == `RCB_OFS_PB_DRV}},
                      {8{reg_wr && ofs == `RCB_OFS_PA_DRV}}};
  assign addr_all  = {16'h0000, addr_high_q, addr_latch_q};

  //////////////////////////////////////////////////////////////////////////
  // Address latch for address-out mode on ports A and B
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      addr_latch_q <= `RCB_RST_BYTE;
      addr_high_q  <= `RCB_RST_BYTE;
    end
    else if (BUS_RD || BUS_WR || BUS_PSEN)
    begin
      addr_latch_q <= ADDR[7:0];
      addr_high_q  <= ADDR[15:8];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Four ports
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gen_port
      rcb_port #(
        .HAS_FUNC (g < 2 ? 1 : 0)
      ) u_port (
        .clk       (CLK),
        .resetn    (RESETN),
        .pin_raw   (PORT_PIN_IN[8*g+7:8*g]),
        .pin_out_q (PORT_PIN_OUT[8*g+7:8*g]),
        .pin_oe_q  (PORT_PIN_OE[8*g+7:8*g]),
        .wdata     (WDATA),
        .wr_func   (wr_func_v[8*g]),
        .wr_out    (wr_out_v[8*g]),
        .wr_dir    (wr_dir_v[8*g]),
        .wr_drv    (wr_drv_v[8*g]),
        .cell_sel  (PORT_CELL_SEL[8*g+7:8*g]),
        .cell_val  (PORT_CELL_VAL[8*g+7:8*g]),
        .addr_val  (addr_all[8*g+7:8*g]),
        .pin_in_q  (pin_in_all[8*g+7:8*g]),
        .func_q    (func_all[8*g+7:8*g]),
        .out_q     (out_all[8*g+7:8*g]),
        .dir_q     (dir_all[8*g+7:8*g]),
        .drv_q     (drv_all[8*g+7:8*g])
      );
    end
  endgenerate
  assign PORT_DRIVE = drv_all;

  //////////////////////////////////////////////////////////////////////////
  // Other writable registers; read-only and unused offsets fall through
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      OUT_CELL_AB  <= `RCB_RST_BYTE;
      OUT_CELL_BC  <= `RCB_RST_BYTE;
      POWER_CTRL_0 <= `RCB_RST_BYTE;
      POWER_CTRL_2 <= `RCB_RST_BYTE;
      POWER_CTRL_3 <= `RCB_RST_BYTE;
      PAGE_SELECT  <= `RCB_RST_BYTE;
      SPACE_MAP    <= `RCB_RST_BYTE;
      map_init_q   <= 1'b0;
      mask_ab_q    <= `RCB_RST_BYTE;
      mask_bc_q    <= `RCB_RST_BYTE;
    end
    else if (!map_init_q)
    begin
      // Strap-like default taken at the first edge after release
      map_init_q <= 1'b1;
      SPACE_MAP  <= NV_MAP_INIT & `RCB_MAP_NV_MASK;
    end
    else if (reg_wr)
    begin
      case (ofs)
        `RCB_OFS_CELL_AB:
          OUT_CELL_AB <= (OUT_CELL_AB & mask_ab_q) | (WDATA & ~mask_ab_q);
        `RCB_OFS_CELL_BC:
          OUT_CELL_BC <= (OUT_CELL_BC & mask_bc_q) | (WDATA & ~mask_bc_q);
        `RCB_OFS_MASK_AB:
          mask_ab_q <= WDATA;
        `RCB_OFS_MASK_BC:
          mask_bc_q <= WDATA;
        `RCB_OFS_PWR0:
          POWER_CTRL_0 <= WDATA;
        `RCB_OFS_PWR2:
          POWER_CTRL_2 <= WDATA;
        `RCB_OFS_PWR3:
          // A written zero cannot drop the sticky bit
          POWER_CTRL_3 <= WDATA | (POWER_CTRL_3 & `RCB_PWR3_STICKY);
        `RCB_OFS_PAGE:
          PAGE_SELECT <= WDATA;
        `RCB_OFS_MAP:
          // Unused map bits stay zero
          SPACE_MAP <= WDATA & (`RCB_MAP_NV_MASK | 8'h80);
        default:
          // Read-only or unused offset: nothing changes
          map_init_q <= map_init_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register read mux
  always @*
  begin
    case (ofs)
      `RCB_OFS_PA_PIN_IN: reg_rdata = pin_in_all[7:0];
      `RCB_OFS_PB_PIN_IN: reg_rdata = pin_in_all[15:8];
      `RCB_OFS_PC_PIN_IN: reg_rdata = pin_in_all[23:16];
      `RCB_OFS_PD_PIN_IN: reg_rdata = pin_in_all[31:24];
      `RCB_OFS_PA_FUNC:   reg_rdata = func_all[7:0];
      `RCB_OFS_PB_FUNC:   reg_rdata = func_all[15:8];
      `RCB_OFS_PA_OUT:    reg_rdata = out_all[7:0];
      `RCB_OFS_PB_OUT:    reg_rdata = out_all[15:8];
      `RCB_OFS_PC_OUT:    reg_rdata = out_all[23:16];
      `RCB_OFS_PD_OUT:    reg_rdata = out_all[31:24];
      `RCB_OFS_PA_DIR:    reg_rdata = dir_all[7:0];
      `RCB_OFS_PB_DIR:    reg_rdata = dir_all[15:8];
      `RCB_OFS_PC_DIR:    reg_rdata = dir_all[23:16];
      `RCB_OFS_PD_DIR:    reg_rdata = dir_all[31:24];
      `RCB_OFS_PA_DRV:    reg_rdata = drv_all[7:0];
      `RCB_OFS_PB_DRV:    reg_rdata = drv_all[15:8];
      `RCB_OFS_PC_DRV:    reg_rdata = drv_all[23:16];
      `RCB_OFS_PD_DRV:    reg_rdata = drv_all[31:24];
      `RCB_OFS_PA_ICELL:  reg_rdata = IN_CELLS_A;
      `RCB_OFS_PB_ICELL:  reg_rdata = IN_CELLS_B;
      `RCB_OFS_PC_ICELL:  reg_rdata = IN_CELLS_C;
      // Status tracks the registered driver enables on the pins
      `RCB_OFS_PA_DEN:    reg_rdata = PORT_PIN_OE[7:0];
      `RCB_OFS_PB_DEN:    reg_rdata = PORT_PIN_OE[15:8];
      `RCB_OFS_PC_DEN:    reg_rdata = PORT_PIN_OE[23:16];
      `RCB_OFS_PD_DEN:    reg_rdata = PORT_PIN_OE[31:24];
      // Masked cells read zero
      `RCB_OFS_CELL_AB:   reg_rdata = OUT_CELL_AB & ~mask_ab_q;
      `RCB_OFS_CELL_BC:   reg_rdata = OUT_CELL_BC & ~mask_bc_q;
      `RCB_OFS_MASK_AB:   reg_rdata = mask_ab_q;
      `RCB_OFS_MASK_BC:   reg_rdata = mask_bc_q;
      `RCB_OFS_MAIN_PROT: reg_rdata = NV_MAIN_PROT;
      `RCB_OFS_SEC_PROT:  reg_rdata = NV_SEC_PROT;
      `RCB_OFS_PWR0:      reg_rdata = POWER_CTRL_0;
      `RCB_OFS_PWR2:      reg_rdata = POWER_CTRL_2;
      `RCB_OFS_PWR3:      reg_rdata = POWER_CTRL_3;
      `RCB_OFS_PAGE:      reg_rdata = PAGE_SELECT;
      `RCB_OFS_MAP:       reg_rdata = SPACE_MAP;
      default:            reg_rdata = `RCB_RST_BYTE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Data-width steering per bus cycle type
  always @*
  begin
    dout_d  = 16'h0000;
    oe_lo_d = 1'b0;
    oe_hi_d = 1'b0;
    if (BUS_PSEN)
    begin
      // SRAM, control block and external never answer a fetch
      if (SRAM_SEL || EXT_SEL || hit)
      begin
        oe_lo_d = 1'b0;
      end
      else if (SEC_SEL && SPACE_MAP[`RCB_MAP_SEC_PROG])
      begin
        // Secondary flash wins where it overlaps main flash
        dout_d  = SEC_DATA;
        oe_lo_d = 1'b1;
        oe_hi_d = !FLASH_PROG;
      end
      else if (MAIN_SEL && SPACE_MAP[`RCB_MAP_MAIN_PROG])
      begin
        dout_d  = MAIN_DATA;
        oe_lo_d = 1'b1;
        oe_hi_d = !FLASH_PROG;
      end
    end
    else if (BUS_RD)
    begin
      // Every data read is byte-wide; upper lane stays off
      oe_lo_d = 1'b1;
      if (hit)
        dout_d = {8'h00, reg_rdata};
      else if (SRAM_SEL)
        dout_d = {8'h00, SRAM_DATA};
      else if (EXT_SEL)
        dout_d = {8'h00, EXT_DATA};
      else if (SEC_SEL && SPACE_MAP[`RCB_MAP_SEC_DATA])
        dout_d = {8'h00, SEC_DATA[7:0]};
      else if (MAIN_SEL && SPACE_MAP[`RCB_MAP_MAIN_DATA])
        dout_d = {8'h00, MAIN_DATA[7:0]};
      else
        oe_lo_d = 1'b0;
    end
  end

  // Registered bus answer
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      DATA_OUT   <= 16'h0000;
      DATA_OE_LO <= 1'b0;
      DATA_OE_HI <= 1'b0;
    end
    else
    begin
      DATA_OUT   <= dout_d;
      DATA_OE_LO <= oe_lo_d;
      DATA_OE_HI <= oe_hi_d;
    end
  end
endmodule

//--- core/rcb_top_fix.v
// (intentionally empty)

//--- tb/rcb_assertions.sv
`include "rcb_consts.vh"
module rcb_assertions (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // Core bus
  input wire logic [15:0] ADDR,
  input wire logic        BUS_RD,
  input wire logic        BUS_PSEN,
  input wire logic        FLASH_PROG,
  input wire logic [7:0]  CSIOP_BASE,
  input wire logic        SRAM_SEL,
  input wire logic        EXT_SEL,
  input wire logic        MAIN_SEL,
  input wire logic        SEC_SEL,
  input wire logic [15:0] MAIN_DATA,
  // Answer and state
  input wire logic [15:0] DATA_OUT,
  input wire logic        DATA_OE_LO,
  input wire logic        DATA_OE_HI,
  input wire logic [7:0]  NV_MAP_INIT,
  input wire logic [7:0]  POWER_CTRL_3,
  input wire logic [7:0]  SPACE_MAP
);
  timeunit 1ns;
  timeprecision 1ps;
  // Register block hit on the upper address byte
  wire hit = (ADDR[15:8] == CSIOP_BASE);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  //////////////////////////////////////////////////////////////////////////////
  // Fetch that only the main array may answer
  sequence s_fetch_main;
    BUS_PSEN && !hit && !SRAM_SEL && !EXT_SEL && !SEC_SEL && MAIN_SEL && SPACE_MAP[2];
  endsequence
  // Data read of a control register
  sequence s_reg_rd;
    BUS_RD && !BUS_PSEN && hit;
  endsequence
  property p_reg_rd;
    s_reg_rd |=> DATA_OE_LO && !DATA_OE_HI;
  endproperty
  a_reg_rd: assert property (p_reg_rd) else $error("register read lanes wrong");
  property p_rd_byte;
    BUS_RD && !BUS_PSEN |=> !DATA_OE_HI;
  endproperty
  a_rd_byte: assert property (p_rd_byte) else $error("data read drove upper lane");
  property p_fetch_main;
    s_fetch_main ##0 !FLASH_PROG |=> DATA_OE_LO && DATA_OE_HI && DATA_OUT == $past(MAIN_DATA);
  endproperty
  a_fetch_main: assert property (p_fetch_main) else $error("fetch word wrong");
  property p_fetch_blk;
    BUS_PSEN && (hit || SRAM_SEL || EXT_SEL) |=> !DATA_OE_LO && !DATA_OE_HI;
  endproperty
  a_fetch_blk: assert property (p_fetch_blk) else $error("byte target answered fetch");
  property p_prog_byte;
    FLASH_PROG |=> !DATA_OE_HI;
  endproperty
  a_prog_byte: assert property (p_prog_byte) else $error("programming cycle not byte");
  property p_map_nv;
    $rose(RESETN) |=> SPACE_MAP == ($past(NV_MAP_INIT) & 8'h1e);
  endproperty
  a_map_nv: assert property (p_map_nv) else $error("map default not restored");
  property p_pio_rst;
    $rose(RESETN) |=> !SPACE_MAP[`RCB_MAP_PIO_BIT];
  endproperty
  a_pio_rst: assert property (p_pio_rst) else $error("peripheral mode not cleared");
  property p_pwr3;
    POWER_CTRL_3[1] |=> POWER_CTRL_3[1];
  endproperty
  a_pwr3: assert property (p_pwr3) else $error("sticky power bit cleared");
endmodule
//////////////////////////////////////////////////////////////////////////////
bind rcb_top rcb_assertions u_chk (
  .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .BUS_RD(BUS_RD), .BUS_PSEN(BUS_PSEN),
  .FLASH_PROG(FLASH_PROG), .CSIOP_BASE(CSIOP_BASE), .SRAM_SEL(SRAM_SEL),
  .EXT_SEL(EXT_SEL), .MAIN_SEL(MAIN_SEL), .SEC_SEL(SEC_SEL), .MAIN_DATA(MAIN_DATA),
  .DATA_OUT(DATA_OUT), .DATA_OE_LO(DATA_OE_LO), .DATA_OE_HI(DATA_OE_HI),
  .NV_MAP_INIT(NV_MAP_INIT), .POWER_CTRL_3(POWER_CTRL_3), .SPACE_MAP(SPACE_MAP)
);

//--- tb/rcb_mem_model.sv
module rcb_mem_model (
  // Core address
  input wire logic [15:0] addr,
  // Array read data, each with its own pattern so misrouting shows
  output logic     [15:0] main_data,
  output logic     [15:0] sec_data,
  output logic     [7:0]  sram_data,
  output logic     [7:0]  ext_data
);
  timeunit 1ns;
  timeprecision 1ps;
  assign main_data = {addr[7:0], ~addr[7:0]};
  assign sec_data  = {~addr[7:0], addr[7:0]};
  assign sram_data = addr[7:0] ^ 8'h55;
  assign ext_data  = addr[7:0] ^ 8'haa;
endmodule

//--- tb/tb_runtime_control_register_bank.sv
`define CHK(nm, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_runtime_control_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0]  PS = 3'b001;
  localparam logic [2:0]  RS = 3'b100;
  localparam logic [15:0] FA = 16'h8012;
  logic        CLK, RESETN, BUS_RD, BUS_WR, BUS_PSEN, FLASH_PROG;
  logic [15:0] ADDR;
  logic [7:0]  WDATA, base, nv_map;
  logic [3:0]  sel;
  logic [31:0] pin_in, cell_sel, cell_val;
  wire  [15:0] main_d, sec_d, data_out;
  wire  [7:0]  sram_d, ext_d, cell_ab, pwr3, smap;
  wire         oe_lo, oe_hi;
  wire  [31:0] pin_out, pin_oe, drive;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc_n = 0;
  //////////////////////////////////////////////////////////////////////////////
  rcb_mem_model MEM (.addr(ADDR), .main_data(main_d), .sec_data(sec_d),
    .sram_data(sram_d), .ext_data(ext_d));
  rcb_top DUT (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .BUS_RD(BUS_RD),
    .BUS_WR(BUS_WR), .BUS_PSEN(BUS_PSEN), .FLASH_PROG(FLASH_PROG), .CSIOP_BASE(base),
    .SRAM_SEL(sel[3]), .EXT_SEL(sel[2]), .MAIN_SEL(sel[1]), .SEC_SEL(sel[0]),
    .MAIN_DATA(main_d), .SEC_DATA(sec_d), .SRAM_DATA(sram_d), .EXT_DATA(ext_d),
    .DATA_OUT(data_out), .DATA_OE_LO(oe_lo), .DATA_OE_HI(oe_hi), .PORT_PIN_IN(pin_in),
    .PORT_PIN_OUT(pin_out), .PORT_PIN_OE(pin_oe), .PORT_DRIVE(drive), .PORT_CELL_SEL(cell_sel),
    .PORT_CELL_VAL(cell_val), .IN_CELLS_A(8'h61), .IN_CELLS_B(8'h62), .IN_CELLS_C(8'h63),
    .OUT_CELL_AB(cell_ab), .OUT_CELL_BC(), .NV_MAIN_PROT(8'h71), .NV_SEC_PROT(8'h82),
    .NV_MAP_INIT(nv_map), .POWER_CTRL_0(), .POWER_CTRL_2(), .POWER_CTRL_3(pwr3),
    .PAGE_SELECT(), .SPACE_MAP(smap));
  // Free-running core clock
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Hang guard, well above the roughly 150 cycles the run needs
  always @(posedge CLK)
  begin
    cyc_n++;
    if (cyc_n == 2000)
    begin
      bad_count++;
      conclude();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // One bus cycle; strobes stay up so back-to-back writes never toggle twice
  task automatic cyc(input logic [2:0] s, input logic [15:0] a, input logic [7:0] d);
    @(negedge CLK);
    {BUS_RD, BUS_WR, BUS_PSEN} = s;
    ADDR = a;
    WDATA = d;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    cyc(3'b010, {base, o}, d);
  endtask
  // Register read, answer checked half a cycle after the taking edge
  task automatic rd(input logic [7:0] o, input logic [7:0] e);
    cyc(RS, {base, o}, 8'h00);
    @(negedge CLK);
    {BUS_RD, BUS_WR, BUS_PSEN} = 3'b000;
    `CHK("read data", e, data_out[7:0])
    `CHK("read lanes", 2'b01, {oe_hi, oe_lo})
  endtask
  // Memory cycle with selects, checking lanes and the data they carry
  task automatic fetch(input logic [2:0] st, input logic [15:0] a, input logic [3:0] s,
                       input logic pg, input logic [1:0] eo, input logic [15:0] ed);
    @(negedge CLK);
    {BUS_RD, BUS_WR, BUS_PSEN} = st;
    ADDR = a;
    sel = s;
    FLASH_PROG = pg;
    @(negedge CLK);
    {BUS_RD, BUS_WR, BUS_PSEN} = 3'b000;
    `CHK("lanes", eo, {oe_hi, oe_lo})
    `CHK("bus data", ed, data_out & {{8{eo[1]}}, {8{eo[0]}}})
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] o [19] = '{8'hb0, 8'hb4, 8'he0, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h22, 8'h23};
    rd(8'h08, 8'h00);
    for (int i = 0; i < 19; i++)
      wr(o[i], 8'h5a ^ 8'(i));
    for (int i = 0; i < 19; i++)
      rd(o[i], 8'h5a ^ 8'(i));
    cyc(3'b010, {base + 8'h01, 8'hb0}, 8'h00);
    rd(8'hb0, 8'h5a);
    `CHK("drive pins", 32'h4a555053, drive)
  endtask
  // Read-only places ignore writes; the unused place is only read back as zero
  task automatic t_ro();
    logic [7:0] o [10] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h0a, 8'h0b, 8'h18, 8'hc0, 8'hc2,
      8'h30};
    logic [7:0] e [10] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h61, 8'h62, 8'h63, 8'h71, 8'h82,
      8'h00};
    for (int i = 0; i < 10; i++)
    begin
      // Unused places are only read; software must never write them
      if (o[i] != 8'h30)
        wr(o[i], 8'hff);
      rd(o[i], e[i]);
    end
  endtask
  task automatic t_cells();
    wr(8'h22, 8'h00);
    wr(8'h20, 8'ha5);
    rd(8'h20, 8'ha5);
    `CHK("cell bank", 8'ha5, cell_ab)
    wr(8'h22, 8'h0f);
    // Masked low nibble keeps its old value and reads back as zero
    wr(8'h20, 8'hff);
    rd(8'h20, 8'hf0);
    `CHK("masked bank", 8'hf5, cell_ab)
  endtask
  task automatic t_pins();
    wr(8'h02, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h06, 8'hff);
    wr(8'h04, 8'h3c);
    wr(8'h17, 8'h00);
    wr(8'h15, 8'hff);
    wr(8'h13, 8'h96);
    rd(8'h0c, 8'hff);
    `CHK("pins a", 8'h3c, pin_out[7:0])
    `CHK("enables a", 8'hff, pin_oe[7:0])
    `CHK("pins d", 8'h96, pin_out[31:24])
    cell_sel = 32'h1;
    cell_val = 32'h1;
    @(negedge CLK);
    @(negedge CLK);
    `CHK("cell pin", 8'h3d, pin_out[7:0])
    rd(8'h04, 8'h3c);
    wr(8'hc7, 8'hff);
    wr(8'hc7, 8'h00);
    rd(8'hc7, 8'h02);
  endtask
  task automatic t_map();
    fetch(PS, FA, 4'b0010, 1'b0, 2'b11, 16'h12ed);
    fetch(PS, FA, 4'b0011, 1'b0, 2'b11, 16'hed12);
    fetch(PS, FA, 4'b0010, 1'b1, 2'b01, 16'h00ed);
    fetch(RS, FA, 4'b0010, 1'b0, 2'b01, 16'h00ed);
    fetch(PS, FA, 4'b1010, 1'b0, 2'b00, 16'h0000);
    fetch(PS, {base, 8'h12}, 4'b0010, 1'b0, 2'b00, 16'h0000);
    fetch(RS, FA, 4'b1010, 1'b0, 2'b01, 16'h0047);
    fetch(RS, FA, 4'b0110, 1'b0, 2'b01, 16'h00b8);
    wr(8'he2, 8'hff);
    rd(8'he2, 8'h9e);
    wr(8'he2, 8'h10);
    fetch(PS, FA, 4'b0010, 1'b0, 2'b00, 16'h0000);
    fetch(RS, FA, 4'b0010, 1'b0, 2'b01, 16'h00ed);
    wr(8'he2, 8'h90);
    rd(8'he2, 8'h90);
    // A different stored default proves reset reloads it
    nv_map = 8'h0c;
    RESETN = 1'b0;
    @(negedge CLK);
    RESETN = 1'b1;
    @(negedge CLK);
    `CHK("map after reset", 8'h0c, smap)
  endtask
  task automatic conclude();
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    RESETN = 1'b0;
    {BUS_RD, BUS_WR, BUS_PSEN} = 3'b000;
    FLASH_PROG = 1'b0;
    ADDR = 16'h0000;
    WDATA = 8'h00;
    base = 8'h20;
    nv_map = 8'hff;
    sel = 4'h0;
    pin_in = 32'h44332211;
    cell_sel = 32'h0;
    cell_val = 32'h0;
    repeat (4) @(negedge CLK);
    RESETN = 1'b1;
    @(negedge CLK);
    `CHK("map default", 8'h1e, smap)
    t_regs();
    t_ro();
    t_cells();
    t_pins();
    t_map();
    conclude();
  end
endmodule
